// ### bench/gpib_controller_model.sv
`timescale 1ns/1ps

// Bus controller: issues common commands, queries and interface messages
module gpib_controller_model (
  // Clock
  input  wire logic                    mclk,
  // Answers from the block
  input  wire logic [7:0]              resp_data_q,
  input  wire logic                    resp_valid_q,
  input  wire gpib_status_pkg::clear_t clr_q,
  // Controller drive
  output gpib_status_pkg::cmd_t        cmd,
  output logic [7:0]                   wdata,
  output gpib_status_pkg::bus_cmd_t    bus,
  output logic                         ren_pin
);
  // Idle drive at time zero
  initial begin
    cmd     = '0;
    wdata   = 8'h00;
    bus     = '0;
    ren_pin = 1'b0;
  end

  // One command pulse; status is only cleared through its causes
  task automatic send(input gpib_status_pkg::cmd_t c, input logic [7:0] v,
                      output logic [7:0] r, output logic ok);
    @(posedge mclk);
    cmd   <= c;
    wdata <= v; // Full 0..255 range
    @(posedge mclk);
    cmd   <= '0;
    wdata <= ~v; // Stale data not left on the lines
    @(posedge mclk);
    r  = resp_data_q;
    ok = resp_valid_q;
  endtask : send

  // One interface message pulse, returns the clear requests seen
  task automatic message(input gpib_status_pkg::bus_cmd_t b,
                         output gpib_status_pkg::clear_t cl);
    @(posedge mclk);
    bus <= b;
    @(posedge mclk);
    bus <= '0;
    @(posedge mclk);
    cl = clr_q;
  endtask : message

  // Remote enable level, held past the pin synchroniser
  task automatic set_ren(input logic v);
    @(posedge mclk);
    ren_pin <= v;
    repeat (4) @(posedge mclk);
  endtask : set_ren
endmodule : gpib_controller_model

// ### bench/ieee488_status_remote_local_tb.sv
`timescale 1ns/1ps

// Self-checking bench for the status and remote/local block
module ieee488_status_remote_local_tb;
  localparam gpib_status_pkg::cmd_t C_ESEW = 9'h100;
  localparam gpib_status_pkg::cmd_t C_SREW = 9'h080;
  localparam gpib_status_pkg::cmd_t C_ESE  = 9'h040;
  localparam gpib_status_pkg::cmd_t C_SRE  = 9'h020;
  localparam gpib_status_pkg::cmd_t C_ESR  = 9'h010;
  localparam gpib_status_pkg::cmd_t C_STB  = 9'h008;
  localparam gpib_status_pkg::cmd_t C_SPL  = 9'h004;
  localparam gpib_status_pkg::cmd_t C_CLS  = 9'h002;
  localparam gpib_status_pkg::cmd_t C_RST  = 9'h001;
  localparam gpib_status_pkg::bus_cmd_t B_IFC = 5'h10;
  localparam gpib_status_pkg::bus_cmd_t B_DCL = 5'h08;
  localparam gpib_status_pkg::bus_cmd_t B_GTL = 5'h04;
  localparam gpib_status_pkg::bus_cmd_t B_LLO = 5'h02;
  localparam gpib_status_pkg::bus_cmd_t B_LSN = 5'h01;

  logic                        mclk;
  logic                        arst_n;
  logic                        ren_pin;
  logic                        local_key_pin;
  logic                        outq_nonempty;
  gpib_status_pkg::event_t     evt;
  gpib_status_pkg::cmd_t       cmd;
  logic [7:0]                  wdata;
  gpib_status_pkg::bus_cmd_t   bus;
  logic [7:0]                  resp_data_q;
  logic                        resp_valid_q;
  logic                        srq_q;
  gpib_status_pkg::clear_t     clr_q;
  gpib_status_pkg::rl_state_t  rl_state;
  logic                        panel_keys_en;
  logic                        local_key_en;
  logic [7:0]                  vals [4] = '{8'h00, 8'hFF, 8'h30, 8'hA5};
  int                          fail_count;
  int                          n_tests;

  // Block under test
  ieee488_status_remote_local dut (
    .mclk(mclk), .arst_n(arst_n), .ren_pin(ren_pin),
    .local_key_pin(local_key_pin), .evt(evt), .outq_nonempty(outq_nonempty),
    .cmd(cmd), .wdata(wdata), .bus(bus), .resp_data_q(resp_data_q),
    .resp_valid_q(resp_valid_q), .srq_q(srq_q), .clr_q(clr_q),
    .rl_state(rl_state), .panel_keys_en(panel_keys_en),
    .local_key_en(local_key_en)
  );

  // Controller on the far side
  gpib_controller_model ctl (
    .mclk(mclk), .resp_data_q(resp_data_q), .resp_valid_q(resp_valid_q),
    .clr_q(clr_q), .cmd(cmd), .wdata(wdata), .bus(bus), .ren_pin(ren_pin)
  );

  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Byte compare
  task automatic chk8(input logic [7:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  // Query with answer check
  task automatic ask(input gpib_status_pkg::cmd_t c, input logic [7:0] exp,
                     input string what);
    logic [7:0] r;
    logic       ok;
    ctl.send(c, 8'h00, r, ok);
    chk8({7'h00, ok}, 8'h01, "answer strobe");
    chk8(r, exp, what);
  endtask : ask

  // Command or register write without answer
  task automatic wr(input gpib_status_pkg::cmd_t c, input logic [7:0] v);
    logic [7:0] r;
    logic       ok;
    ctl.send(c, v, r, ok);
  endtask : wr

  // Control state and key gating
  task automatic chk_rl(input gpib_status_pkg::rl_state_t st);
    chk8({6'h00, rl_state}, {6'h00, st}, "control state");
    chk8({6'h00, panel_keys_en, local_key_en},
         {6'h00, st == gpib_status_pkg::RL_LOCAL,
          st != gpib_status_pkg::RL_LOCKOUT}, "key gating");
  endtask : chk_rl

  // Interface message with clear and state check
  task automatic msg(input gpib_status_pkg::bus_cmd_t b, input logic [3:0] cl,
                     input gpib_status_pkg::rl_state_t st);
    gpib_status_pkg::clear_t got;
    ctl.message(b, got);
    chk8({4'h0, got}, {4'h0, cl}, "clear requests");
    chk_rl(st);
  endtask : msg

  // Event pulse
  task automatic pulse(input gpib_status_pkg::event_t e);
    @(posedge mclk);
    evt <= e;
    @(posedge mclk);
    evt <= '0;
  endtask : pulse

  // Front local key press past the synchroniser
  task automatic key();
    @(posedge mclk);
    local_key_pin <= 1'b1;
    repeat (5) @(posedge mclk);
    local_key_pin <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : key

  // Power-up reset held 10 cycles
  task automatic do_reset();
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    chk8({4'h0, clr_q}, 8'h0F, "power-up clear");
    arst_n <= 1'b1;
  endtask : do_reset

  // Verdict and end of run
  task automatic print_verdict();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Watchdog
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end

  // Test sequence
  initial begin
    arst_n        = 1'b0;
    local_key_pin = 1'b0;
    outq_nonempty = 1'b0;
    evt           = '0;
    fail_count    = 0;
    n_tests       = 0;
    do_reset();
    chk_rl(gpib_status_pkg::RL_LOCAL);
    ask(C_ESR, 8'h80, "power-on event");
    ask(C_ESR, 8'h00, "event cleared by read");
    ask(C_ESE, 8'h00, "mask at power-up");
    for (int i = 0; i < 4; i++) begin
      wr(C_ESEW, vals[i]);
      ask(C_ESE, vals[i], "mask readback");
    end
    wr(C_ESEW, 8'h10);
    pulse(6'h10);
    ask(C_STB, 8'h20, "event summary");
    ask(C_STB, 8'h20, "status query clears nothing");
    wr(C_SREW, 8'h20);
    repeat (2) @(posedge mclk);
    chk8({7'h00, srq_q}, 8'h01, "service request");
    ask(C_STB, 8'h60, "master summary");
    ask(C_SPL, 8'h60, "poll shows request");
    ask(C_SPL, 8'h20, "poll cleared request");
    ask(C_STB, 8'h60, "summary kept after poll");
    ask(C_ESR, 8'h10, "execution error bit");
    ask(C_STB, 8'h00, "summary gone with cause");
    wr(C_SREW, 8'hCC);
    pulse(6'h10);
    repeat (3) @(posedge mclk);
    chk8({7'h00, srq_q}, 8'h00, "non-source enable");
    ask(C_STB, 8'h20, "no summary from other bits");
    wr(C_SREW, 8'h33);
    ask(C_SRE, 8'h33, "request mask readback");
    @(posedge mclk);
    outq_nonempty <= 1'b1;
    ask(C_STB, 8'h70, "message available");
    wr(C_CLS, 8'h00);
    chk8({7'h00, srq_q}, 8'h00, "clear-status drops request");
    ask(C_STB, 8'h50, "clear-status keeps queue");
    @(posedge mclk);
    outq_nonempty <= 1'b0;
    ask(C_STB, 8'h00, "queue drained");
    pulse(6'h3F);
    ask(C_ESR, 8'h39, "event layout");
    ask(C_STB, 8'h43, "local bus bits request");
    wr(C_RST, 8'h00);
    ask(C_STB, 8'h00, "reset clears status");
    ask(C_ESE, 8'h00, "reset clears mask");
    ask(C_SRE, 8'h00, "reset clears request mask");
    msg(B_IFC, 4'h8, gpib_status_pkg::RL_LOCAL);
    ctl.set_ren(1'b1);
    msg(B_LSN, 4'h0, gpib_status_pkg::RL_REMOTE);
    msg(B_IFC, 4'h8, gpib_status_pkg::RL_REMOTE);
    key();
    chk_rl(gpib_status_pkg::RL_LOCAL);
    msg(B_LSN, 4'h0, gpib_status_pkg::RL_REMOTE);
    msg(B_GTL, 4'h0, gpib_status_pkg::RL_LOCAL);
    msg(B_LSN, 4'h0, gpib_status_pkg::RL_REMOTE);
    msg(B_LLO, 4'h0, gpib_status_pkg::RL_LOCKOUT);
    key();
    chk_rl(gpib_status_pkg::RL_LOCKOUT);
    wr(C_RST, 8'h00);
    chk_rl(gpib_status_pkg::RL_LOCKOUT);
    msg(B_DCL, 4'hF, gpib_status_pkg::RL_LOCAL);
    msg(B_LSN, 4'h0, gpib_status_pkg::RL_REMOTE);
    ctl.set_ren(1'b0);
    chk_rl(gpib_status_pkg::RL_LOCAL);
    wr(C_ESEW, 8'hFF);
    wr(C_SREW, 8'hFF);
    do_reset();
    ask(C_ESE, 8'h00, "mask forced at power-on");
    ask(C_ESR, 8'h80, "power-on event again");
    ask(C_SRE, 8'h00, "request mask at power-on");
    print_verdict();
  end
endmodule : ieee488_status_remote_local_tb

// ### design/ieee488_status_remote_local.sv
`timescale 1ns/1ps
`include "gpib_status_map.svh"

module ieee488_status_remote_local (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      arst_n,
  // Pins from outside the clock domain
  input  wire logic                      ren_pin,
  input  wire logic                      local_key_pin,
  // Event sources
  input  wire gpib_status_pkg::event_t   evt,
  input  wire logic                      outq_nonempty,
  // Commands and write data
  input  wire gpib_status_pkg::cmd_t     cmd,
  input  wire logic [7:0]                wdata,
  input  wire gpib_status_pkg::bus_cmd_t bus,
  // Query answer
  output logic [7:0]                     resp_data_q,
  output logic                           resp_valid_q,
  // Service request and clears
  output logic                           srq_q,
  output gpib_status_pkg::clear_t        clr_q,
  // Remote / local
  output gpib_status_pkg::rl_state_t     rl_state,
  output logic                           panel_keys_en,
  output logic                           local_key_en
);

  localparam logic [7:0] ESR_RST = `ESR_RST_VAL;
  localparam logic [7:0] ESR_USE = `ESR_USED_MASK;

  logic [1:0] ren_sync_q;
  logic [2:0] key_sync_q;
  logic       ren_s;
  logic       key_press;
  logic [7:0] esr_set;
  logic [7:0] event_status;
  logic [7:0] ese_q;
  logic [7:0] sre_q;
  logic       status_clr;
  logic       esr_clr;
  logic       lbus_err_q;
  logic       lbus_timeout_q;
  logic       esb;
  logic [7:0] stb;
  logic       mss;
  logic       mss_q;
  logic       any_rd;

  // Pin synchronisers; key edge taken after the second stage
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ren_sync_q <= 2'h0;
      key_sync_q <= 3'h0;
    end else begin
      ren_sync_q <= {ren_sync_q[0], ren_pin};
      key_sync_q <= {key_sync_q[1:0], local_key_pin};
    end
  end

  assign ren_s     = ren_sync_q[1];
  assign key_press = key_sync_q[1] & ~key_sync_q[2];

  // Status clearing sources
  assign status_clr = cmd.cls | cmd.rst | bus.dcl;
  assign esr_clr    = status_clr | cmd.esr_rd;

  // Event inputs mapped onto their bit positions
  always_comb begin
    esr_set                = 8'h00;
    esr_set[`ESR_CME_BIT]  = evt.cmd_err;
    esr_set[`ESR_EXE_BIT]  = evt.exe_err;
    esr_set[`ESR_ALARM_BIT] = evt.alarm;
    esr_set[`ESR_OPC_BIT]  = evt.op_done;
  end

  // Event status register, unused bits never set
  generate
    for (genvar i = 0; i < 8; i++) begin : g_esr
      status_flag #(
        .RST_VAL (ESR_RST[i])
      ) u_flag (
        .mclk    (mclk),
        .arst_n  (arst_n),
        .set     (esr_set[i] & ESR_USE[i]),
        .clr     (esr_clr),
        .q       (event_status[i])
      );
    end
  endgenerate

  // Local bus error and timeout status bits
  status_flag #(
    .RST_VAL (1'b0)
  ) u_lbus_err (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .set     (evt.lbus_err),
    .clr     (status_clr),
    .q       (lbus_err_q)
  );

  status_flag #(
    .RST_VAL (1'b0)
  ) u_lbus_timeout (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .set     (evt.lbus_timeout),
    .clr     (status_clr),
    .q       (lbus_timeout_q)
  );

  // Event enable mask; reset command wins over a write
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ese_q <= `ESE_RST_VAL;
    end else if (cmd.rst) begin
      ese_q <= `ESE_RST_VAL;
    end else if (cmd.ese_wr) begin
      ese_q <= wdata;
    end
  end

  // Service request enable mask
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sre_q <= `SRE_RST_VAL;
    end else if (cmd.rst) begin
      sre_q <= `SRE_RST_VAL;
    end else if (cmd.sre_wr) begin
      sre_q <= wdata;
    end
  end

  // Status byte summary; bit 6 filled per read path
  assign esb = |(event_status & ese_q);
  always_comb begin
    stb                = 8'h00;
    stb[`STB_ESB_BIT]  = esb;
    stb[`STB_MAV_BIT]  = outq_nonempty;
    stb[`STB_LBUS_ERR_BIT]     = lbus_err_q;
    stb[`STB_LBUS_TIMEOUT_BIT] = lbus_timeout_q;
  end
  assign mss = |(stb & sre_q & `STB_SRQ_SRC);

  // Request flag: set on summary rise, cleared by poll, status clear or summary loss
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mss_q <= 1'b0;
      srq_q <= 1'b0;
    end else begin
      mss_q <= mss;
      if (mss && !mss_q) begin
        srq_q <= 1'b1;
      end else if (!mss || cmd.spoll_rd || status_clr) begin
        srq_q <= 1'b0;
      end
    end
  end

  // Query answers, one answer per cycle in fixed priority
  assign any_rd = cmd.ese_rd | cmd.sre_rd | cmd.esr_rd
                | cmd.stb_rd | cmd.spoll_rd;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      resp_data_q  <= 8'h00;
      resp_valid_q <= 1'b0;
    end else begin
      resp_valid_q <= any_rd;
      if (cmd.esr_rd) begin
        resp_data_q <= event_status;
      end else if (cmd.ese_rd) begin
        resp_data_q <= ese_q;
      end else if (cmd.sre_rd) begin
        resp_data_q <= sre_q;
      end else if (cmd.stb_rd) begin
        resp_data_q <= stb | {1'b0, mss, 6'h00};
      end else if (cmd.spoll_rd) begin
        resp_data_q <= stb | {1'b0, srq_q, 6'h00};
      end
    end
  end

  // Clear requests; asserted out of reset for the power-up clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clr_q <= 4'hF;
    end else begin
      clr_q.addressed <= bus.ifc | bus.dcl | cmd.rst;
      clr_q.input_buf <= bus.dcl | cmd.rst;
      clr_q.out_queue <= bus.dcl | cmd.rst;
      clr_q.pending   <= bus.dcl | cmd.rst;
    end
  end

  // Remote / local state tracking
  remote_local_fsm u_rl (
    .mclk          (mclk),
    .arst_n        (arst_n),
    .ren           (ren_s),
    .local_key     (key_press),
    .bus           (bus),
    .state_q       (rl_state),
    .panel_keys_en (panel_keys_en),
    .local_key_en  (local_key_en)
  );

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence s_esr_read;
    cmd.esr_rd && esr_set == 8'h00;
  endsequence

  sequence s_go_remote;
    rl_state == gpib_status_pkg::RL_LOCAL && ren_s && bus.listen_addr
      && !bus.dcl && !bus.llo;
  endsequence

  // Summary bit as answered, against the masked event bits of that cycle
  property p_esb_summary;
    logic m;
    ((cmd.stb_rd || cmd.spoll_rd) && !cmd.esr_rd && !cmd.ese_rd
      && !cmd.sre_rd, m = |(event_status & ese_q))
      |=> resp_data_q[`STB_ESB_BIT] == m;
  endproperty
  a_esb_summary: assert property (p_esb_summary)
    else $error("event summary bit mismatch");

  property p_esr_read_clears;
    logic [7:0] v;
    (s_esr_read, v = event_status) |=> event_status == 8'h00 && resp_valid_q
                              && resp_data_q == v;
  endproperty
  a_esr_read_clears: assert property (p_esr_read_clears)
    else $error("event read did not answer and clear");

  property p_stb_read_keeps;
    cmd.stb_rd && !status_clr && !cmd.esr_rd && !cmd.spoll_rd
      && !cmd.ese_rd && !cmd.sre_rd
      && evt == '0 && $stable(outq_nonempty) && mss == mss_q
      |=> $stable(srq_q)
      && resp_data_q[`STB_MSS_BIT] == $past(mss);
  endproperty
  a_stb_read_keeps: assert property (p_stb_read_keeps)
    else $error("status query altered state or bit 6");

  property p_rqs_on_rise;
    mss && !mss_q |=> srq_q;
  endproperty
  a_rqs_on_rise: assert property (p_rqs_on_rise)
    else $error("service request not raised");

  property p_poll_clears;
    cmd.spoll_rd && !(mss && !mss_q) |=> !srq_q ##0 resp_valid_q
      && resp_data_q[`STB_MSS_BIT] == $past(srq_q);
  endproperty
  a_poll_clears: assert property (p_poll_clears)
    else $error("serial poll did not clear request");

  property p_summary_gone;
    !mss |=> !srq_q;
  endproperty
  a_summary_gone: assert property (p_summary_gone)
    else $error("request held without summary");

  property p_dcl_local;
    bus.dcl && !(mss && !mss_q) |=> rl_state == gpib_status_pkg::RL_LOCAL
      && clr_q.out_queue && !srq_q ##1 !clr_q.out_queue;
  endproperty
  a_dcl_local: assert property (p_dcl_local)
    else $error("device clear effects wrong");

  property p_enter_remote;
    s_go_remote |=> rl_state != gpib_status_pkg::RL_LOCAL
      && !panel_keys_en;
  endproperty
  a_enter_remote: assert property (p_enter_remote)
    else $error("remote not entered when addressed");

  property p_ifc_only_addr;
    bus.ifc && !bus.dcl && !cmd.rst && !bus.gtl && ren_s && !cmd.ese_wr
      && !key_press && !bus.listen_addr && !bus.llo
      |=> clr_q.addressed && !clr_q.out_queue
      && $stable(rl_state) && $stable(ese_q);
  endproperty
  a_ifc_only_addr: assert property (p_ifc_only_addr)
    else $error("interface clear touched more than addressing");

  property p_rst_masks;
    cmd.rst |=> ese_q == 8'h00 && sre_q == 8'h00 && clr_q.input_buf;
  endproperty
  a_rst_masks: assert property (p_rst_masks)
    else $error("reset did not clear masks");

  property p_one_state;
    rl_state == gpib_status_pkg::RL_LOCAL
      || rl_state == gpib_status_pkg::RL_REMOTE
      || rl_state == gpib_status_pkg::RL_LOCKOUT;
  endproperty
  a_one_state: assert property (p_one_state)
    else $error("illegal remote/local state");

endmodule : ieee488_status_remote_local

// ### design/remote_local_fsm.sv
`timescale 1ns/1ps

// Local / remote / remote-with-lockout tracking
module remote_local_fsm (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    arst_n,
  // Synchronised inputs
  input  wire logic                    ren,
  input  wire logic                    local_key,
  // Interface messages
  input  wire gpib_status_pkg::bus_cmd_t bus,
  // State and key gating
  output gpib_status_pkg::rl_state_t   state_q,
  output logic                         panel_keys_en,
  output logic                         local_key_en
);

  gpib_status_pkg::rl_state_t state_d;
  logic                       llo_q;
  logic                       llo_now;

  assign llo_now = llo_q | bus.llo;

  // Lockout request remembered until REN drops or device clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      llo_q <= 1'b0;
    end else if (bus.llo && ren) begin
      llo_q <= 1'b1;
    end else if (!ren || bus.dcl) begin
      llo_q <= 1'b0;
    end
  end

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      gpib_status_pkg::RL_LOCAL: begin
        if (bus.listen_addr && ren && !bus.dcl) begin
          state_d = llo_now ? gpib_status_pkg::RL_LOCKOUT
                            : gpib_status_pkg::RL_REMOTE;
        end
      end
      gpib_status_pkg::RL_REMOTE: begin
        if (!ren || bus.dcl || bus.gtl || local_key) begin
          state_d = gpib_status_pkg::RL_LOCAL;
        end else if (bus.llo) begin
          state_d = gpib_status_pkg::RL_LOCKOUT;
        end
      end
      gpib_status_pkg::RL_LOCKOUT: begin
        if (!ren || bus.dcl || bus.gtl) begin
          state_d = gpib_status_pkg::RL_LOCAL;
        end
      end
      default: begin
        state_d = gpib_status_pkg::RL_LOCAL;
      end
    endcase
  end

  // Power-up enters local
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= gpib_status_pkg::RL_LOCAL;
    end else begin
      state_q <= state_d;
    end
  end

  // Key gating: remote leaves local key, lockout leaves none
  assign panel_keys_en = (state_q == gpib_status_pkg::RL_LOCAL);
  assign local_key_en  = (state_q != gpib_status_pkg::RL_LOCKOUT);

endmodule : remote_local_fsm

// ### design/status_flag.sv
`timescale 1ns/1ps

// Sticky flag; a set in the same cycle as a clear wins
module status_flag #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // Control
  input  wire logic set,
  input  wire logic clr,
  // State
  output logic      q
);

  // Set has priority over clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RST_VAL;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end

endmodule : status_flag

// ### inc/gpib_status_map.svh
`ifndef GPIB_STATUS_MAP_SVH
`define GPIB_STATUS_MAP_SVH

// Event status register bit positions
`define ESR_PON_BIT   7
`define ESR_CME_BIT   5
`define ESR_EXE_BIT   4
`define ESR_ALARM_BIT 3
`define ESR_OPC_BIT   0
// Implemented event bits and power-up value
`define ESR_USED_MASK 8'hB9
`define ESR_RST_VAL   8'h80
`define ESE_RST_VAL   8'h00
`define SRE_RST_VAL   8'h00

// Status byte bit positions
`define STB_MSS_BIT   6
`define STB_ESB_BIT   5
`define STB_MAV_BIT   4
`define STB_LBUS_ERR_BIT     1
`define STB_LBUS_TIMEOUT_BIT 0
// Status byte bits able to raise a service request
`define STB_SRQ_SRC   8'h33

`endif

// ### inc/gpib_status_pkg.sv
package gpib_status_pkg;

  // Interface control state
  typedef enum logic [1:0] {
    RL_LOCAL   = 2'b00,
    RL_REMOTE  = 2'b01,
    RL_LOCKOUT = 2'b10
  } rl_state_t;

  // Event sources, one-cycle pulses
  typedef struct packed {
    logic cmd_err;
    logic exe_err;
    logic alarm;
    logic op_done;
    logic lbus_err;
    logic lbus_timeout;
  } event_t;

  // Decoded common commands and queries, one-cycle pulses
  typedef struct packed {
    logic ese_wr;
    logic sre_wr;
    logic ese_rd;
    logic sre_rd;
    logic esr_rd;
    logic stb_rd;
    logic spoll_rd;
    logic cls;
    logic rst;
  } cmd_t;

  // Interface messages, one-cycle pulses
  typedef struct packed {
    logic ifc;
    logic dcl;
    logic gtl;
    logic llo;
    logic listen_addr;
  } bus_cmd_t;

  // Clear requests to the surrounding interface logic
  typedef struct packed {
    logic addressed;
    logic input_buf;
    logic out_queue;
    logic pending;
  } clear_t;

endpackage : gpib_status_pkg
